// *** include/cbt_pkg.sv ***
// constants shared by the compact branch and trap decoder
package cbt_pkg;
  // ***************************************************************
  // instruction group codes
  // ***************************************************************
  localparam logic [3:0]  GRP_COND_TRAP   = 4'hD;   // bits 15:12
  localparam logic [4:0]  GRP_JUMP        = 5'h1C;  // bits 15:11
  localparam logic [3:0]  GRP_LONG_CALL   = 4'hF;   // bits 15:12
  localparam logic [3:0]  COND_UNDEF      = 4'hE;
  localparam logic [3:0]  COND_TRAP       = 4'hF;

  // ***************************************************************
  // addresses and field positions
  // ***************************************************************
  localparam logic [31:0] PREFETCH_BYTES  = 32'h0000_0004;
  localparam logic [31:0] NEXT_INSTR_BYTES = 32'h0000_0002;
  localparam logic [31:0] TRAP_VECTOR     = 32'h0000_0008;
  localparam int          STAT_N_POS      = 31;
  localparam int          STAT_Z_POS      = 30;
  localparam int          STAT_C_POS      = 29;
  localparam int          STAT_V_POS      = 28;
  localparam int          STAT_T_POS      = 5;
  localparam logic [4:0]  MODE_SUPERVISOR = 5'h13;  // supervisor mode code loaded on trap entry
  localparam logic [31:0] RESET_WORD      = 32'h0000_0000;

  // ***************************************************************
  // execution cycle counts
  // ***************************************************************
  localparam logic [1:0]  CYC_TAKEN       = 2'h3;
  localparam logic [1:0]  CYC_NOT_TAKEN   = 2'h1;
  localparam logic [1:0]  CYC_TRAP        = 2'h3;
  localparam logic [1:0]  CYC_CALL_HIGH   = 2'h1;
  localparam logic [1:0]  CYC_CALL_LOW    = 2'h3;
  localparam logic [1:0]  CYC_OTHER       = 2'h1;

  typedef enum logic {CBT_IDLE, CBT_BUSY} cbt_state_e;
endpackage : cbt_pkg

// *** include/cbt_exec_if.sv ***
// signals shared between the decoder core, condition check and target adder
`timescale 1ns/1ns
interface cbt_exec_if;
  logic [15:0] word;
  logic [31:0] pcAhead;
  logic [31:0] linkIn;
  logic [3:0]  nzcv;
  logic        condTaken;
  logic        isTrap;
  logic        isUndef;
  logic [31:0] condTarget;
  logic [31:0] jumpTarget;
  logic [31:0] callHighLink;
  logic [31:0] callLowTarget;
  logic [31:0] returnLink;

  modport eval (input word, nzcv, output condTaken, isTrap, isUndef);
  modport calc (input word, pcAhead, linkIn,
                output condTarget, jumpTarget, callHighLink, callLowTarget, returnLink);
  modport core (output word, pcAhead, linkIn, nzcv,
                input condTaken, isTrap, isUndef, condTarget, jumpTarget,
                      callHighLink, callLowTarget, returnLink);
endinterface : cbt_exec_if

// *** design/cbt_cond_eval.sv ***
// condition field evaluation against the arithmetic flags
`timescale 1ns/1ns
module cbt_cond_eval (
  cbt_exec_if.eval ex
);
  import cbt_pkg::*;

  logic n, z, c, v;
  assign {n, z, c, v} = ex.nzcv;

  // ***************************************************************
  // condition table
  // ***************************************************************
  always_comb begin
    case (ex.word[11:8])
      4'h0: ex.condTaken = z;
      4'h1: ex.condTaken = !z;
      4'h2: ex.condTaken = c;
      4'h3: ex.condTaken = !c;
      4'h4: ex.condTaken = n;
      4'h5: ex.condTaken = !n;
      4'h6: ex.condTaken = v;
      4'h7: ex.condTaken = !v;
      4'h8: ex.condTaken = c && !z;
      4'h9: ex.condTaken = !c || z;
      4'hA: ex.condTaken = (n == v);
      4'hB: ex.condTaken = (n != v);
      4'hC: ex.condTaken = !z && (n == v);
      4'hD: ex.condTaken = z || (n != v);
      default: ex.condTaken = 1'b0;         // undefined and trap never branch
    endcase
  end

  // codes that are not branches at all
  assign ex.isUndef = (ex.word[11:8] == COND_UNDEF);
  assign ex.isTrap  = (ex.word[11:8] == COND_TRAP);
endmodule : cbt_cond_eval

// *** design/cbt_target_calc.sv ***
// branch, call and return address arithmetic
`timescale 1ns/1ns
module cbt_target_calc (
  cbt_exec_if.calc ex
);
  import cbt_pkg::*;

  logic [7:0]  shortOff;
  logic [10:0] jumpOff;
  assign shortOff = ex.word[7:0];
  assign jumpOff  = ex.word[10:0];

  // ***************************************************************
  // targets relative to the prefetched pc, except the call low half, which adds to the link value
  // ***************************************************************
  assign ex.condTarget    = ex.pcAhead + {{23{shortOff[7]}}, shortOff, 1'b0};
  assign ex.jumpTarget    = ex.pcAhead + {{20{jumpOff[10]}}, jumpOff, 1'b0};
  assign ex.callHighLink  = ex.pcAhead + {{9{jumpOff[10]}}, jumpOff, 12'h000};
  // low half is unsigned, sign already sits in the link value
  assign ex.callLowTarget = ex.linkIn + {20'h00000, jumpOff, 1'b0};
  // return point is the halfword after the call, marked in bit 0
  assign ex.returnLink    = (ex.pcAhead - NEXT_INSTR_BYTES) | 32'h0000_0001;
endmodule : cbt_target_calc

// *** design/cbt_branch_decoder.sv ***
// compact control-flow group decoder and executor
//
// Contract
// - targets use pc one word ahead; flags decide conditional branches
// - code 0000 branches on zero set, 0001 on zero clear
// - code 0010 branches on carry set, 0011 on carry clear
// - code 0100 branches on negative set, 0101 on negative clear
// - code 0110 branches on overflow set, 0111 on overflow clear
// - 1000 branches carry set and zero clear; 1001 the inverse
// - 1010 branches negative equals overflow; 1011 when they differ
// - 1100 zero clear and N equals V; 1101 the inverse
// - short offset sign-extended, doubled, added to prefetched pc
// - code 1110 undefined; code 1111 is the software trap
// - trap writes next address to link, saves status, jumps to 0x8
// - trap enters wide instruction state and supervisor mode
// - trap comment field has no effect on hardware
// - unconditional branch adds doubled signed 11-bit offset to pc
// - call high half: offset shifted by 12 plus pc into link
// - call low half: doubled offset plus link loaded into pc
// - branch and trap take the same cycles as wide equivalents
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module cbt_branch_decoder (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        instrValid,
  input  wire logic [15:0] instrWord,
  input  wire logic [31:0] instrAddr,
  input  wire logic [31:0] statusIn,
  input  wire logic [31:0] linkIn,
  output logic             instrReady,
  output logic             execDone,
  output logic             pcWrite,
  output logic [31:0]      pcValue,
  output logic             linkWrite,
  output logic [31:0]      linkValue,
  output logic             savedWrite,
  output logic [31:0]      savedValue,
  output logic             statusWrite,
  output logic [31:0]      statusValue,
  output logic             undefTrap
);
  import cbt_pkg::*;

  cbt_exec_if ex ();

  cbt_cond_eval u_cond (
    .ex (ex.eval)
  );

  cbt_target_calc u_calc (
    .ex (ex.calc)
  );

  // ***************************************************************
  // operands into the helpers
  // ***************************************************************
  assign ex.word    = instrWord;
  assign ex.pcAhead = instrAddr + PREFETCH_BYTES;
  assign ex.linkIn  = linkIn;
  assign ex.nzcv    = {statusIn[STAT_N_POS], statusIn[STAT_Z_POS],
                       statusIn[STAT_C_POS], statusIn[STAT_V_POS]};

  // ***************************************************************
  // group decode
  // ***************************************************************
  logic isCondGrp;
  logic isJump;
  logic isCall;
  logic accept;
  assign isCondGrp = (instrWord[15:12] == GRP_COND_TRAP);
  assign isJump    = (instrWord[15:11] == GRP_JUMP);
  assign isCall    = (instrWord[15:12] == GRP_LONG_CALL);
  assign accept    = instrValid && instrReady;

  // ***************************************************************
  // state and result registers
  // ***************************************************************
  cbt_state_e  state_ff, nxt_state;
  logic [1:0]  cnt_ff, nxt_cnt;
  logic [4:0]  pend_ff, nxt_pend;  // pc, link, saved, status, undef
  logic [31:0] pcVal_ff, nxt_pcVal;
  logic [31:0] linkVal_ff, nxt_linkVal;
  logic [31:0] savedVal_ff, nxt_savedVal;
  logic [31:0] statVal_ff, nxt_statVal;
  logic [4:0]  strobe_ff, nxt_strobe;
  logic        done_ff, nxt_done;
  logic        ready_ff, nxt_ready;
  logic [31:0] trapStatus;

  // trap status: wide state, supervisor mode, flags kept
  always_comb begin
    trapStatus = statusIn;
    trapStatus[STAT_T_POS] = 1'b0;
    trapStatus[4:0] = MODE_SUPERVISOR;
  end

  // next-state: load results on accept, release strobes when count expires
  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_pend     = pend_ff;
    nxt_pcVal    = pcVal_ff;
    nxt_linkVal  = linkVal_ff;
    nxt_savedVal = savedVal_ff;
    nxt_statVal  = statVal_ff;
    nxt_strobe   = 5'h00;
    nxt_done     = 1'b0;
    nxt_ready    = ready_ff;
    case (state_ff)
      CBT_IDLE: begin
        if (accept) begin
          nxt_state = CBT_BUSY;
          nxt_ready = 1'b0;
          nxt_pend  = 5'h00;
          nxt_cnt   = CYC_OTHER - 2'h1;
          if (isCondGrp && ex.isTrap) begin
            // comment field deliberately never looked at
            nxt_pcVal    = TRAP_VECTOR;
            nxt_linkVal  = ex.pcAhead - NEXT_INSTR_BYTES;
            nxt_savedVal = statusIn;
            nxt_statVal  = trapStatus;
            nxt_pend     = 5'h0F;
            nxt_cnt      = CYC_TRAP - 2'h1;
          end else if (isCondGrp && ex.isUndef) begin
            // undefined code: raise a flag, leave pc to the core
            nxt_pend = 5'h10;
          end else if (isCondGrp && ex.condTaken) begin
            nxt_pcVal = ex.condTarget;
            nxt_pend  = 5'h01;
            nxt_cnt   = CYC_TAKEN - 2'h1;
          end else if (isCondGrp) begin
            nxt_cnt = CYC_NOT_TAKEN - 2'h1;
          end else if (isJump) begin
            nxt_pcVal = ex.jumpTarget;
            nxt_pend  = 5'h01;
            nxt_cnt   = CYC_TAKEN - 2'h1;
          end else if (isCall && !instrWord[11]) begin
            nxt_linkVal = ex.callHighLink;
            nxt_pend    = 5'h02;
            nxt_cnt     = CYC_CALL_HIGH - 2'h1;
          end else if (isCall) begin
            nxt_pcVal   = ex.callLowTarget;
            nxt_linkVal = ex.returnLink;
            nxt_pend    = 5'h03;
            nxt_cnt     = CYC_CALL_LOW - 2'h1;
          end
        end
      end
      CBT_BUSY: begin
        if (cnt_ff == 2'h0) begin
          nxt_state  = CBT_IDLE;
          nxt_strobe = pend_ff;
          nxt_done   = 1'b1;
          nxt_ready  = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 2'h1;
        end
      end
      default: begin
        nxt_state = CBT_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  // registers only; results stay put between instructions
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= CBT_IDLE;
      cnt_ff      <= 2'h0;
      pend_ff     <= 5'h00;
      pcVal_ff    <= RESET_WORD;
      linkVal_ff  <= RESET_WORD;
      savedVal_ff <= RESET_WORD;
      statVal_ff  <= RESET_WORD;
      strobe_ff   <= 5'h00;
      done_ff     <= 1'b0;
      ready_ff    <= 1'b1;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      pend_ff     <= nxt_pend;
      pcVal_ff    <= nxt_pcVal;
      linkVal_ff  <= nxt_linkVal;
      savedVal_ff <= nxt_savedVal;
      statVal_ff  <= nxt_statVal;
      strobe_ff   <= nxt_strobe;
      done_ff     <= nxt_done;
      ready_ff    <= nxt_ready;
    end
  end

  // ***************************************************************
  // outputs, all straight from flip-flops
  // ***************************************************************
  assign instrReady  = ready_ff;
  assign execDone    = done_ff;
  assign pcWrite     = strobe_ff[0];
  assign linkWrite   = strobe_ff[1];
  assign savedWrite  = strobe_ff[2];
  assign statusWrite = strobe_ff[3];
  assign undefTrap   = strobe_ff[4];
  assign pcValue     = pcVal_ff;
  assign linkValue   = linkVal_ff;
  assign savedValue  = savedVal_ff;
  assign statusValue = statVal_ff;

  // ***************************************************************
  // checks
  // ***************************************************************
  logic acceptCond;
  assign acceptCond = accept && isCondGrp;

  AST_PREFETCH_TARGET: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && ex.condTaken && !ex.isTrap
      |=> pcVal_ff == $past(instrAddr) + 32'h4 + {{23{$past(instrWord[7])}},
                                                   $past(instrWord[7:0]), 1'b0})
    else $error("conditional target not taken from prefetched pc");
  AST_COND_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && instrWord[11:9] == 3'h0 |-> ex.condTaken == (statusIn[30] ^ instrWord[8]))
    else $error("zero condition wrong");
  AST_COND_CARRY: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && instrWord[11:9] == 3'h1 |-> ex.condTaken == (statusIn[29] ^ instrWord[8]))
    else $error("carry condition wrong");
  AST_COND_NEG: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && instrWord[11:9] == 3'h2 |-> ex.condTaken == (statusIn[31] ^ instrWord[8]))
    else $error("negative condition wrong");
  AST_COND_OVF: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && instrWord[11:9] == 3'h3 |-> ex.condTaken == (statusIn[28] ^ instrWord[8]))
    else $error("overflow condition wrong");
  AST_COND_HIGHER: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && instrWord[11:9] == 3'h4
      |-> ex.condTaken == ((statusIn[29] && !statusIn[30]) ^ instrWord[8]))
    else $error("unsigned higher condition wrong");
  AST_COND_GE: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && instrWord[11:9] == 3'h5
      |-> ex.condTaken == ((statusIn[31] == statusIn[28]) ^ instrWord[8]))
    else $error("signed compare condition wrong");
  AST_COND_GT: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && instrWord[11:9] == 3'h6
      |-> ex.condTaken == ((!statusIn[30] && statusIn[31] == statusIn[28]) ^ instrWord[8]))
    else $error("greater-than condition wrong");
  AST_UNDEF_NO_BRANCH: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && instrWord[11:8] == 4'hE |-> ##1 !pcWrite ##1 undefTrap && !pcWrite)
    else $error("undefined code treated as branch");
  AST_TRAP_ENTRY: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && instrWord[11:8] == 4'hF
      |-> ##4 pcWrite && pcValue == 32'h8 && linkWrite && linkValue == $past(instrAddr, 4) + 32'h2
          && savedWrite && savedValue == $past(statusIn, 4))
    else $error("trap entry wrong");
  AST_TRAP_MODE: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && instrWord[11:8] == 4'hF
      |-> ##4 statusWrite && !statusValue[5] && statusValue[4:0] == 5'h13)
    else $error("trap did not enter supervisor wide state");
  AST_JUMP_TARGET: assert property (@(posedge clk_sys) disable iff (!rstn)
    accept && instrWord[15:11] == 5'h1C
      |-> ##4 pcWrite && pcValue == $past(instrAddr, 4) + 32'h4
          + {{20{$past(instrWord[10], 4)}}, $past(instrWord[10:0], 4), 1'b0})
    else $error("unconditional branch wrong");
  AST_CALL_HIGH: assert property (@(posedge clk_sys) disable iff (!rstn)
    accept && instrWord[15:11] == 5'h1E
      |-> ##2 linkWrite && !pcWrite && linkValue == $past(instrAddr, 2) + 32'h4
          + {{9{$past(instrWord[10], 2)}}, $past(instrWord[10:0], 2), 12'h000})
    else $error("long call high half wrong");
  AST_CALL_LOW: assert property (@(posedge clk_sys) disable iff (!rstn)
    accept && instrWord[15:11] == 5'h1F
      |-> ##4 pcWrite && pcValue == $past(linkIn, 4) + {20'h0, $past(instrWord[10:0], 4), 1'b0}
          && linkValue == ($past(instrAddr, 4) + 32'h2 | 32'h1))
    else $error("long call low half wrong");
  AST_TAKEN_CYCLES: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && ex.condTaken |-> ##1 !execDone[*3] ##1 execDone)
    else $error("taken branch cycle count wrong");
  AST_SKIP_CYCLES: assert property (@(posedge clk_sys) disable iff (!rstn)
    acceptCond && !ex.condTaken && !ex.isTrap |-> ##2 execDone && !pcWrite)
    else $error("skipped branch cycle count wrong");
endmodule : cbt_branch_decoder

// *** dv/test_compact_branch_trap_decoder.sv ***
// self-checking bench for the compact branch and trap decoder
`timescale 1ns/1ns

// compare one output with its expected value and count the result
`define CBT_CHECK(got, exp, what) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp); \
    end \
  end

module test_compact_branch_trap_decoder;
  import cbt_pkg::*;

  // ***************************************************************
  // signals and expectation record
  // ***************************************************************
  typedef struct {
    int          lat;
    logic        pcW;
    logic [31:0] pc;
    logic        linkW;
    logic [31:0] link;
    logic        savedW;
    logic [31:0] saved;
    logic        statW;
    logic [31:0] stat;
    logic        undef;
  } cbt_exp_s;

  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic [31:0] instrAddr = 32'h0000_0000;
  logic [31:0] statusIn = 32'h0000_0000;
  logic [31:0] linkIn = 32'h0000_0000;
  logic        instrReady, execDone, pcWrite, linkWrite, savedWrite, statusWrite, undefTrap;
  logic [31:0] pcValue, linkValue, savedValue, statusValue;
  int          err_count = 0;
  int          num_checks = 0;
  integer      seed = 18295;

  always #4 clk_sys = ~clk_sys;

  cbt_branch_decoder uut (
    .clk_sys(clk_sys), .rstn(rstn), .instrValid(instrValid), .instrWord(instrWord),
    .instrAddr(instrAddr), .statusIn(statusIn), .linkIn(linkIn), .instrReady(instrReady),
    .execDone(execDone), .pcWrite(pcWrite), .pcValue(pcValue), .linkWrite(linkWrite),
    .linkValue(linkValue), .savedWrite(savedWrite), .savedValue(savedValue),
    .statusWrite(statusWrite), .statusValue(statusValue), .undefTrap(undefTrap)
  );

  // ***************************************************************
  // reference model of the control-flow group
  // ***************************************************************
  function automatic logic cond_true(input logic [3:0] c, input logic [31:0] s);
    logic n, z, cy, v;
    n = s[STAT_N_POS];
    z = s[STAT_Z_POS];
    cy = s[STAT_C_POS];
    v = s[STAT_V_POS];
    case (c)
      4'h0: return z;
      4'h1: return !z;
      4'h2: return cy;
      4'h3: return !cy;
      4'h4: return n;
      4'h5: return !n;
      4'h6: return v;
      4'h7: return !v;
      4'h8: return cy && !z;
      4'h9: return !cy || z;
      4'hA: return n == v;
      4'hB: return n != v;
      4'hC: return !z && (n == v);
      4'hD: return z || (n != v);
      default: return 1'b0;
    endcase
  endfunction : cond_true

  function automatic cbt_exp_s expect_of(input logic [15:0] w, input logic [31:0] addr,
                                         input logic [31:0] stat, input logic [31:0] link);
    cbt_exp_s    e;
    logic [31:0] ahead;
    e = '{default: '0};
    e.lat = 1;
    ahead = addr + 32'h0000_0004;
    if (w[15:12] == 4'hD) begin
      if (w[11:8] == 4'hE) begin
        e.undef = 1'b1;
      end else if (w[11:8] == 4'hF) begin
        // trap: return address, saved status, wide state, supervisor mode
        e.lat = 3;
        {e.pcW, e.linkW, e.savedW, e.statW} = 4'hF;
        e.pc = 32'h0000_0008;
        e.link = addr + 32'h0000_0002;
        e.saved = stat;
        e.stat = {stat[31:6], 1'b0, 5'h13};
      end else if (cond_true(w[11:8], stat)) begin
        e.lat = 3;
        e.pcW = 1'b1;
        e.pc = ahead + {{23{w[7]}}, w[7:0], 1'b0};
      end
    end else if (w[15:11] == 5'h1C) begin
      e.lat = 3;
      e.pcW = 1'b1;
      e.pc = ahead + {{20{w[10]}}, w[10:0], 1'b0};
    end else if (w[15:12] == 4'hF && !w[11]) begin
      e.linkW = 1'b1;
      e.link = ahead + {{9{w[10]}}, w[10:0], 12'h000};
    end else if (w[15:12] == 4'hF) begin
      // low half: offset taken unsigned, return address odd
      e.lat = 3;
      {e.pcW, e.linkW} = 2'h3;
      e.pc = link + {20'h00000, w[10:0], 1'b0};
      e.link = (addr + 32'h0000_0002) | 32'h0000_0001;
    end
    return e;
  endfunction : expect_of

  // ***************************************************************
  // one instruction through the decoder
  // ***************************************************************
  // inputs are scrambled after accept so late sampling shows up; poke offers a
  // second word while busy, which must be ignored
  task automatic run(input logic [15:0] w, input logic [31:0] addr, input logic [31:0] stat,
                     input logic [31:0] link, input bit poke);
    cbt_exp_s e;
    int       n;
    e = expect_of(w, addr, stat, link);
    @(posedge clk_sys);
    instrValid <= 1'b1;
    instrWord <= w;
    instrAddr <= addr;
    statusIn <= stat;
    linkIn <= link;
    #1;
    `CBT_CHECK(execDone, 1'b0, "done pulse too long")
    `CBT_CHECK(pcWrite, 1'b0, "pc strobe too long")
    @(posedge clk_sys);
    instrValid <= poke && (e.lat > 1);
    instrWord <= 16'hD000;
    instrAddr <= ~addr;
    statusIn <= ~stat;
    linkIn <= ~link;
    // the accept edge has just passed; done lands lat edges after it
    n = 0;
    #1;
    if (e.lat > 1) `CBT_CHECK(instrReady, 1'b0, "ready while busy")
    while (execDone !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      instrValid <= 1'b0;
      n++;
      #1;
    end
    `CBT_CHECK(n, e.lat, "latency")
    `CBT_CHECK(instrReady, 1'b1, "ready at done")
    `CBT_CHECK(pcWrite, e.pcW, "pc strobe")
    `CBT_CHECK(linkWrite, e.linkW, "link strobe")
    `CBT_CHECK(savedWrite, e.savedW, "saved strobe")
    `CBT_CHECK(statusWrite, e.statW, "status strobe")
    `CBT_CHECK(undefTrap, e.undef, "undefined flag")
    if (e.pcW) `CBT_CHECK(pcValue, e.pc, "pc value")
    if (e.linkW) `CBT_CHECK(linkValue, e.link, "link value")
    if (e.savedW) `CBT_CHECK(savedValue, e.saved, "saved value")
    if (e.statW) `CBT_CHECK(statusValue, e.stat, "status value")
  endtask : run

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin : main_seq
    static logic [15:0] corners [14] = '{16'hD07F, 16'hD080, 16'hE3FF, 16'hE400, 16'hF3FF,
                                  16'hF400, 16'hFFFF, 16'hF800, 16'hDF00, 16'hDFFF,
                                  16'hDE12, 16'h0000, 16'hB500, 16'hE800};
    cbt_exp_s    hi;
    logic [31:0] a;
    logic [15:0] w;
    repeat (4) @(posedge clk_sys);
    #1;
    `CBT_CHECK(instrReady, 1'b1, "ready in reset")
    `CBT_CHECK(pcValue, 32'h0000_0000, "pc value in reset")
    rstn <= 1'b1;
    $display("test reset done");
    // boundary offsets, comment field extremes, undefined and foreign words
    foreach (corners[i]) run(corners[i], 32'h0000_1000 + 32'(i * 2), 32'h4000_003F,
                             32'h0001_0000, 1'b1);
    $display("test corners done");
    // every branch condition against every flag combination
    for (int c = 0; c < 14; c++) begin
      for (int f = 0; f < 16; f++) begin
        run({4'hD, 4'(c), 8'($random(seed))}, {$random(seed)} & 32'hFFFF_FFFE,
            {4'(f), 28'($random(seed))}, $random(seed), 1'b0);
      end
    end
    $display("test conditions done");
    // long call halves fed back to back through the link value
    for (int i = 0; i < 20; i++) begin
      a = {$random(seed)} & 32'hFFFF_FFFE;
      w = {5'h1E, 11'($random(seed))};
      hi = expect_of(w, a, 32'h0000_0000, 32'h0000_0000);
      run(w, a, $random(seed), $random(seed), 1'b0);
      run({5'h1F, 11'($random(seed))}, a + 32'h2, $random(seed), hi.link, 1'b1);
    end
    $display("test long call done");
    // random words biased towards the control-flow groups
    for (int i = 0; i < 200; i++) begin
      w = $random(seed);
      if (i % 2) w[15:13] = 3'b111;
      else w[15:12] = 4'hD;
      run(w, {$random(seed)} & 32'hFFFF_FFFE, $random(seed), $random(seed),
          (i % 3) == 0);
    end
    $display("test random done");
    end_sim();
  end : main_seq

  // hang guard, far beyond the few thousand cycles the tests need
  initial begin : watchdog
    #(8 * 40000);
    err_count++;
    $display("wrong value at %0t: run did not finish", $time);
    end_sim();
  end : watchdog
endmodule : test_compact_branch_trap_decoder
